// File: common/sdcbd_pkg.sv
// Shared constants and types for the registered SDRAM command and burst decoder.
// Assumes one 100 MHz clock (mclk) and a synchronous active-high reset.
package sdcbd_pkg;

    // ==========================================================
    // Widths and fields
    localparam int ADDR_W = 12;
    localparam int COL_W = 10;
    localparam int BANKS = 4;
    localparam int DQ_W = 64;
    localparam int MASK_W = 8;
    localparam int AP_BIT = 10;
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int PAGE_COLS_LARGE = 1024;
    localparam int FIFO_DEPTH = 4;

    // ==========================================================
    // Burst length codes held in the mode register
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;

    // ==========================================================
    // Reset values
    localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;
    localparam logic [ADDR_W-1:0] RFSH_ROW_RESET = 12'h000;
    localparam logic [MASK_W-1:0] OE_N_RESET = 8'hff;

    // ==========================================================
    // Decoded commands and burst states
    typedef enum logic [8:0] {
        CMD_NOP = 9'h001,
        CMD_ACT = 9'h002,
        CMD_RD = 9'h004,
        CMD_WR = 9'h008,
        CMD_BST = 9'h010,
        CMD_PRE = 9'h020,
        CMD_REF = 9'h040,
        CMD_LMR = 9'h080,
        CMD_INH = 9'h100
    } sdcbd_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_READ = 3'h2,
        ST_WRITE = 3'h4
    } sdcbd_state_t;

    // ==========================================================
    // Pin group and column beat carried to the array
    typedef struct packed {
        logic sel_a_n;
        logic sel_b_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic [1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic [MASK_W-1:0] mask;
        logic [DQ_W-1:0] wdata;
    } sdcbd_pins_t;

    typedef struct packed {
        logic wr;
        logic [1:0] bank;
        logic [COL_W-1:0] col;
        logic auto_pre;
        logic last;
        logic [MASK_W-1:0] mask;
        logic [DQ_W-1:0] data;
    } sdcbd_beat_t;

    localparam sdcbd_pins_t PINS_IDLE = '{sel_a_n: 1'b1, sel_b_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                          we_n: 1'b1, cke: 1'b1, default: '0};

endpackage : sdcbd_pkg

// File: rtl/sdcbd_burst.sv
// Column sequencer for one read or write burst.
// Assumes the caller restarts it with start and stops it with stop.
`timescale 1ns/1ps
module sdcbd_burst #(
    parameter int PAGE_COLS = sdcbd_pkg::PAGE_COLS_LARGE
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic start,
    input wire logic stop,
    input wire logic step,
    input wire logic [sdcbd_pkg::COL_W-1:0] start_col,
    input wire logic [2:0] bl_code,
    input wire logic interleave,
    // Sequence
    output logic active,
    output logic last,
    output logic [sdcbd_pkg::COL_W-1:0] col
);
    localparam int CW = sdcbd_pkg::COL_W;

    logic [CW-1:0] base_q, base_d, beat_q, beat_d, m, low;
    logic [2:0] bl_q, bl_d;
    logic il_q, il_d, act_q, act_d;

    // Wrap mask of the aligned block for a burst length code
    function automatic logic [CW-1:0] blk_mask(input logic [2:0] code);
        unique case (code)
            sdcbd_pkg::BL_2: blk_mask = 10'h001;
            sdcbd_pkg::BL_4: blk_mask = 10'h003;
            sdcbd_pkg::BL_8: blk_mask = 10'h007;
            sdcbd_pkg::BL_PAGE: blk_mask = CW'(PAGE_COLS - 1);
            default: blk_mask = 10'h000;
        endcase
    endfunction : blk_mask

    // ==========================================================
    // Column address of the current beat
    always_comb begin
        m = blk_mask(bl_q);
        if (il_q && bl_q != sdcbd_pkg::BL_PAGE) begin
            low = (base_q & m) ^ beat_q;
        end else begin
            low = (base_q + beat_q) & m;
        end
        col = (base_q & ~m) | (low & m);
        last = (bl_q != sdcbd_pkg::BL_PAGE) && (beat_q == m);
        active = act_q;
    end

    // Next sequencer state
    always_comb begin
        base_d = base_q;
        beat_d = beat_q;
        bl_d = bl_q;
        il_d = il_q;
        act_d = act_q;
        if (start) begin
            base_d = start_col;
            beat_d = '0;
            bl_d = bl_code;
            il_d = interleave;
            act_d = 1'b1;
        end else if (stop) begin
            act_d = 1'b0;
        end else if (act_q && step) begin
            beat_d = beat_q + 1'b1;
            act_d = !last;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            base_q <= '0;
            beat_q <= '0;
            bl_q <= sdcbd_pkg::BL_1;
            il_q <= 1'b0;
            act_q <= 1'b0;
        end else begin
            base_q <= base_d;
            beat_q <= beat_d;
            bl_q <= bl_d;
            il_q <= il_d;
            act_q <= act_d;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_block_wrap: assert property (act_q && step && !last && !start && !stop
                                   && (!il_q || bl_q == sdcbd_pkg::BL_PAGE)
                                   |=> (col & ~m) == ($past(col) & ~m)
                                   && ((col - $past(col)) & m) == CW'(1))
        else $error("sequential burst skipped a column or left its block");
    a_single_beat: assert property (start && bl_code == sdcbd_pkg::BL_1 ##1 step && !start |-> last ##1 !act_q)
        else $error("length one burst did not end after one beat");

endmodule : sdcbd_burst

// File: rtl/sdcbd_fifo.sv
// Small synchronous FIFO for column beats on their way to the array.
// Assumes one clock; the drain side may stall at any time.
`timescale 1ns/1ps
module sdcbd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    // ==========================================================
    // Flags and pointers
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    // Pointer registers and storage
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_fifo_no_overflow: assert property ((wr_q - rd_q) <= (AW+1)'(DEPTH))
        else $error("fifo holds more words than its depth");

endmodule : sdcbd_fifo

// File: rtl/sdcbd_top.sv
// Command decoder and burst column sequencer of a registered SDRAM module.
// Assumes the controller pins arrive from outside the mclk domain and the array
// side accepts column beats over valid/ready and returns read data as a pulse.
//
// Overview of operation
// - Activate opens row in selected bank
// - Read command starts read burst at column
// - Write command starts burst; data arrives with it
// - Column from low bits, bit ten requests precharge
// - Precharge command closes open rows
// - Bit ten low one bank, high all
// - Refresh command decoded from row and column strobes low, write strobe high
// - Clock enable picks auto or self refresh
// - Refresh uses internal row counter, ignores inputs
// - Mode register load takes address op-code
// - Byte mask: writes immediate, reads two clocks
// - Length two wraps within two-column block
// - Length four sequential or interleaved order
// - Length eight sequential or interleaved order
// - Bursts wrap inside their aligned block
// - Full page runs sequentially through row
// - Length one single column, type ignored
// - Chip selects high mask every command
// - Input register adds one clock latency; here two stages add two
`timescale 1ns/1ps
module sdcbd_top #(
    parameter int PAGE_COLS = sdcbd_pkg::PAGE_COLS_LARGE,
    parameter int FIFO_DEPTH = sdcbd_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Command pins from the controller
    input wire logic select_lane_a_n,
    input wire logic select_lane_b_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic module_clock_enable,
    input wire logic bank_select_lo,
    input wire logic bank_select_hi,
    input wire logic [sdcbd_pkg::ADDR_W-1:0] addr,
    input wire logic [sdcbd_pkg::MASK_W-1:0] byte_mask,
    // Data pins
    input wire logic [sdcbd_pkg::DQ_W-1:0] dq_in,
    output logic [sdcbd_pkg::DQ_W-1:0] dq_out,
    output logic [sdcbd_pkg::MASK_W-1:0] dq_oe_n,
    // Row and refresh events to the array
    output logic act_pulse,
    output logic [1:0] act_bank,
    output logic [sdcbd_pkg::ADDR_W-1:0] act_row,
    output logic pre_pulse,
    output logic [sdcbd_pkg::BANKS-1:0] pre_banks,
    output logic rfsh_pulse,
    output logic [sdcbd_pkg::ADDR_W-1:0] rfsh_row,
    // Column beats to the array
    output logic beat_valid,
    input wire logic beat_ready,
    output sdcbd_pkg::sdcbd_beat_t beat,
    // Read data from the array
    input wire logic rd_valid,
    input wire logic [sdcbd_pkg::DQ_W-1:0] rd_data,
    // Status
    output logic [sdcbd_pkg::ADDR_W-1:0] mode_value,
    output logic [sdcbd_pkg::BANKS-1:0] open_banks,
    output logic self_refresh,
    output logic wr_overrun
);
    typedef sdcbd_pkg::sdcbd_pins_t pins_t;
    typedef sdcbd_pkg::sdcbd_cmd_t cmd_t;
    typedef sdcbd_pkg::sdcbd_state_t state_t;
    localparam int AW = sdcbd_pkg::ADDR_W;
    localparam int MW = sdcbd_pkg::MASK_W;
    localparam int NB = sdcbd_pkg::BANKS;

    pins_t pins, s1_q, s2_q;
    cmd_t cmd;
    state_t st_q, st_d;
    logic [AW-1:0] mode_q, mode_d, rrow_q, rrow_d, rf_row_q, rf_row_d, act_row_q, act_row_d;
    logic [NB-1:0] open_q, open_d, pre_banks_q, pre_banks_d;
    logic [1:0] bank_q, bank_d, act_bank_q, act_bank_d;
    logic ap_q, ap_d, self_q, self_d, act_p_q, act_p_d, pre_p_q, pre_p_d, rf_p_q, rf_p_d;
    logic [MW-1:0] wmask_q, mask_d1_q, mask_d2_q, oe_n_q, oe_n_d;
    logic [sdcbd_pkg::DQ_W-1:0] wdata_q, dq_q, dq_d;
    logic drop_q, drop_d;
    logic b_start, b_stop, b_step, b_active, b_last, fifo_in_ready;
    logic [sdcbd_pkg::COL_W-1:0] b_col;
    sdcbd_pkg::sdcbd_beat_t beat_in;

    // Decode one registered pin set into a command
    function automatic cmd_t decode(input pins_t p);
        if (p.sel_a_n && p.sel_b_n) begin
            decode = sdcbd_pkg::CMD_INH;
        end else begin
            unique case ({p.ras_n, p.cas_n, p.we_n})
                3'b011: decode = sdcbd_pkg::CMD_ACT;
                3'b101: decode = sdcbd_pkg::CMD_RD;
                3'b100: decode = sdcbd_pkg::CMD_WR;
                3'b110: decode = sdcbd_pkg::CMD_BST;
                3'b010: decode = sdcbd_pkg::CMD_PRE;
                3'b001: decode = sdcbd_pkg::CMD_REF;
                3'b000: decode = sdcbd_pkg::CMD_LMR;
                default: decode = sdcbd_pkg::CMD_NOP;
            endcase
        end
    endfunction : decode

    // ==========================================================
    // Input register: two stages, the second is the module register
    assign pins = '{sel_a_n: select_lane_a_n, sel_b_n: select_lane_b_n, ras_n: row_strobe_n,
                    cas_n: col_strobe_n, we_n: write_strobe_n, cke: module_clock_enable,
                    bank: {bank_select_hi, bank_select_lo}, addr: addr, mask: byte_mask, wdata: dq_in};

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_q <= sdcbd_pkg::PINS_IDLE;
            s2_q <= sdcbd_pkg::PINS_IDLE;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
        end
    end

    // Commands are dropped while in self refresh
    assign cmd = self_q ? sdcbd_pkg::CMD_NOP : decode(s2_q);

    // ==========================================================
    // Burst sequencer and beat FIFO
    assign b_start = (cmd == sdcbd_pkg::CMD_RD) || (cmd == sdcbd_pkg::CMD_WR);
    assign b_stop = (cmd == sdcbd_pkg::CMD_BST) || (cmd == sdcbd_pkg::CMD_PRE);
    // Writes cannot wait for their data, reads stall on a full FIFO
    assign b_step = (st_q == sdcbd_pkg::ST_WRITE) || fifo_in_ready;

    sdcbd_burst #(.PAGE_COLS(PAGE_COLS)) u_burst (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(b_start),
        .stop(b_stop),
        .step(b_step),
        .start_col(s2_q.addr[sdcbd_pkg::COL_W-1:0]),
        .bl_code(mode_q[sdcbd_pkg::MR_BL_LSB +: 3]),
        .interleave(mode_q[sdcbd_pkg::MR_BT_BIT]),
        .active(b_active),
        .last(b_last),
        .col(b_col)
    );

    // Column beat with write data and mask taken the same cycle
    always_comb begin
        beat_in.wr = st_q == sdcbd_pkg::ST_WRITE;
        beat_in.bank = bank_q;
        beat_in.col = b_col;
        beat_in.auto_pre = ap_q;
        beat_in.last = b_last;
        beat_in.mask = beat_in.wr ? wmask_q : '0;
        beat_in.data = wdata_q;
    end

    sdcbd_fifo #(.WIDTH($bits(sdcbd_pkg::sdcbd_beat_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(b_active),
        .in_ready(fifo_in_ready),
        .in_data(beat_in),
        .out_valid(beat_valid),
        .out_ready(beat_ready),
        .out_data(beat)
    );

    // ==========================================================
    // Command execution, row state and refresh
    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        open_d = open_q;
        bank_d = bank_q;
        ap_d = ap_q;
        self_d = self_q;
        rrow_d = rrow_q;
        rf_row_d = rf_row_q;
        act_p_d = 1'b0;
        act_bank_d = act_bank_q;
        act_row_d = act_row_q;
        pre_p_d = 1'b0;
        pre_banks_d = '0;
        rf_p_d = 1'b0;
        // Burst end, with its optional auto precharge
        if (b_active && b_last && b_step) begin
            st_d = sdcbd_pkg::ST_IDLE;
            if (ap_q) begin
                pre_p_d = 1'b1;
                pre_banks_d = NB'(1) << bank_q;
            end
        end
        if (self_q) begin
            if (s2_q.cke) begin
                self_d = 1'b0;
            end
        end
        unique case (cmd)
            sdcbd_pkg::CMD_ACT: begin
                act_p_d = 1'b1;
                act_bank_d = s2_q.bank;
                act_row_d = s2_q.addr;
                open_d[s2_q.bank] = 1'b1;
            end
            sdcbd_pkg::CMD_RD, sdcbd_pkg::CMD_WR: begin
                st_d = (cmd == sdcbd_pkg::CMD_RD) ? sdcbd_pkg::ST_READ : sdcbd_pkg::ST_WRITE;
                bank_d = s2_q.bank;
                ap_d = s2_q.addr[sdcbd_pkg::AP_BIT];
            end
            sdcbd_pkg::CMD_BST: st_d = sdcbd_pkg::ST_IDLE;
            sdcbd_pkg::CMD_PRE: begin
                st_d = sdcbd_pkg::ST_IDLE;
                pre_p_d = 1'b1;
                pre_banks_d = s2_q.addr[sdcbd_pkg::AP_BIT] ? '1 : (NB'(1) << s2_q.bank);
            end
            sdcbd_pkg::CMD_REF: begin
                if (s2_q.cke) begin
                    rf_p_d = 1'b1;
                    rf_row_d = rrow_q;
                    rrow_d = rrow_q + 1'b1;
                end else begin
                    self_d = 1'b1;
                end
            end
            sdcbd_pkg::CMD_LMR: mode_d = s2_q.addr;
            default: ;
        endcase
        open_d = open_d & ~pre_banks_d;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= sdcbd_pkg::ST_IDLE;
            mode_q <= sdcbd_pkg::MODE_RESET;
            open_q <= '0;
            bank_q <= '0;
            ap_q <= 1'b0;
            self_q <= 1'b0;
            rrow_q <= sdcbd_pkg::RFSH_ROW_RESET;
            rf_row_q <= sdcbd_pkg::RFSH_ROW_RESET;
            act_p_q <= 1'b0;
            act_bank_q <= '0;
            act_row_q <= '0;
            pre_p_q <= 1'b0;
            pre_banks_q <= '0;
            rf_p_q <= 1'b0;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            open_q <= open_d;
            bank_q <= bank_d;
            ap_q <= ap_d;
            self_q <= self_d;
            rrow_q <= rrow_d;
            rf_row_q <= rf_row_d;
            act_p_q <= act_p_d;
            act_bank_q <= act_bank_d;
            act_row_q <= act_row_d;
            pre_p_q <= pre_p_d;
            pre_banks_q <= pre_banks_d;
            rf_p_q <= rf_p_d;
        end
    end

    // ==========================================================
    // Data path: write capture, read drive with delayed byte mask
    always_comb begin
        dq_d = rd_valid ? rd_data : dq_q;
        oe_n_d = rd_valid ? mask_d2_q : sdcbd_pkg::OE_N_RESET;
        drop_d = (st_q == sdcbd_pkg::ST_WRITE) && b_active && !fifo_in_ready;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wdata_q <= '0;
            wmask_q <= '0;
            mask_d1_q <= '0;
            mask_d2_q <= '0;
            dq_q <= '0;
            oe_n_q <= sdcbd_pkg::OE_N_RESET;
            drop_q <= 1'b0;
        end else begin
            wdata_q <= s2_q.wdata;
            wmask_q <= s2_q.mask;
            mask_d1_q <= s2_q.mask;
            mask_d2_q <= mask_d1_q;
            dq_q <= dq_d;
            oe_n_q <= oe_n_d;
            drop_q <= drop_d;
        end
    end

    // Outputs
    assign dq_out = dq_q;
    assign dq_oe_n = oe_n_q;
    assign act_pulse = act_p_q;
    assign act_bank = act_bank_q;
    assign act_row = act_row_q;
    assign pre_pulse = pre_p_q;
    assign pre_banks = pre_banks_q;
    assign rfsh_pulse = rf_p_q;
    assign rfsh_row = rf_row_q;
    assign mode_value = mode_q;
    assign open_banks = open_q;
    assign self_refresh = self_q;
    assign wr_overrun = drop_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_mask_seen;
        s2_q.mask[0] && !self_q;
    endsequence

    a_act_opens: assert property (cmd == sdcbd_pkg::CMD_ACT |=> act_pulse && open_q[act_bank])
        else $error("activate did not open the bank");
    a_read_start: assert property (cmd == sdcbd_pkg::CMD_RD |=> st_q == sdcbd_pkg::ST_READ && b_active)
        else $error("read command did not start a read burst");
    a_write_data: assert property (cmd == sdcbd_pkg::CMD_WR |=> beat_in.wr && beat_in.data == $past(s2_q.wdata))
        else $error("write burst lost the data given with the command");
    a_pre_all: assert property (cmd == sdcbd_pkg::CMD_PRE && s2_q.addr[10] |=> pre_banks == 4'hf && open_q == 4'h0)
        else $error("precharge all did not close all banks");
    a_self_entry: assert property (cmd == sdcbd_pkg::CMD_REF && !s2_q.cke |=> self_refresh && !rfsh_pulse)
        else $error("self refresh entry mishandled");
    a_mode_load: assert property (cmd == sdcbd_pkg::CMD_LMR |=> mode_value == $past(s2_q.addr))
        else $error("mode register not loaded");
    a_inhibit_masks: assert property (s2_q.sel_a_n && s2_q.sel_b_n |=> !act_pulse && !rfsh_pulse
                                      && $stable(mode_value))
        else $error("command acted while deselected");
    a_read_hiz: assert property (s_mask_seen ##2 rd_valid |=> dq_oe_n[0])
        else $error("read byte mask did not float the byte two clocks later");
    a_pin_latency: assert property (!select_lane_a_n && !row_strobe_n && col_strobe_n && write_strobe_n
                                    && !self_q ##2 !self_q |=> act_pulse)
        else $error("activate not seen after the input register delay");

endmodule : sdcbd_top

// File: sim/sdcbd_host.sv
// Host controller model driving command, mask and write data pins.
// Assumes mclk from the bench; idle pins have both selects high.
`timescale 1ns/1ps
module sdcbd_host (
    // Clock and pins
    input wire logic mclk,
    output sdcbd_pkg::sdcbd_pins_t p
);
    // ==========================================================
    // One command held for one cycle, then idle
    initial p = sdcbd_pkg::PINS_IDLE;
    task automatic issue(input logic [3:0] c, input logic k, input logic [1:0] b, input logic [11:0] a,
                         input logic [7:0] m = 8'h00, input logic [63:0] d = 64'h0);
        @(posedge mclk);
        #1;
        p = '{c[3], 1'b1, c[2], c[1], c[0], k, b, a, m, d};
        @(posedge mclk);
        #1;
        p = sdcbd_pkg::PINS_IDLE;
    endtask : issue
endmodule : sdcbd_host

// File: sim/tb_sdcbd_top.sv
// Bench for the command decoder and burst sequencer.
// Assumes the host model drives pins; the bench plays the array side.
`timescale 1ns/1ps
module tb_sdcbd_top;
    logic mclk, sys_rst, beat_ready, act_pulse, pre_pulse, rfsh_pulse, beat_valid, self_refresh;
    logic [1:0] act_bank;
    logic [3:0] pre_banks, open_banks;
    logic [11:0] act_row, mode_value, rfsh_row;
    logic rd_valid, wr_overrun;
    logic [7:0] dq_oe_n;
    logic [63:0] rd_data, dq_out;
    int ovr_n = 0;
    sdcbd_pkg::sdcbd_pins_t p;
    sdcbd_pkg::sdcbd_beat_t beat, got_b;
    logic [9:0] cols[$];
    int err_total = 0;
    int check_count = 0;
    // ==========================================================
    // Clock, host and design
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    sdcbd_host h (.mclk, .p);
    sdcbd_top dut (.mclk, .sys_rst, .select_lane_a_n(p.sel_a_n), .select_lane_b_n(p.sel_b_n),
        .row_strobe_n(p.ras_n), .col_strobe_n(p.cas_n), .write_strobe_n(p.we_n),
        .module_clock_enable(p.cke), .bank_select_lo(p.bank[0]), .bank_select_hi(p.bank[1]),
        .addr(p.addr), .byte_mask(p.mask), .dq_in(p.wdata), .dq_out, .dq_oe_n, .act_pulse,
        .act_bank, .act_row, .pre_pulse, .pre_banks, .rfsh_pulse, .rfsh_row, .beat_valid,
        .beat_ready, .beat, .rd_valid, .rd_data, .mode_value, .open_banks,
        .self_refresh, .wr_overrun);
    // Array side takes each beat handed over and counts dropped writes
    always @(posedge mclk) begin
        if (wr_overrun === 1'b1) ovr_n++;
        if (beat_valid === 1'b1 && beat_ready === 1'b1) begin
            cols.push_back(beat.col);
            got_b = beat;
        end
    end
    // ==========================================================
    // Report, compare and waits
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic cmp(input logic [127:0] g, input logic [127:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    // Issue spent the sampling edge; two more reach the registered outputs
    task automatic wt();
        repeat (2) @(posedge mclk);
        #1;
    endtask : wt
    // Bounded wait for n beats; a held ready is let go after 13 cycles
    task automatic take(input int n);
        for (int i = 0; i < 60 && cols.size() < n; i++) begin
            @(posedge mclk);
            #1;
            if (i == 12) beat_ready = 1'b1;
        end
        if (cols.size() < n) begin
            err_total++;
            test_done();
        end
    endtask : take
    // Program the mode, read one burst, check column order and count
    task automatic burst(input logic [2:0] bl, input logic il, input logic [9:0] s);
        int n;
        logic [9:0] w;
        logic [11:0] op;
        n = 1 << bl;
        w = n[9:0] - 10'h1;
        op = {5'h00, 3'h2, il, bl};
        h.issue(4'h0, 1'b1, 2'h0, op);
        wt();
        cmp(mode_value, op);
        cols.delete();
        beat_ready = (n != 8 || il);
        h.issue(4'h5, 1'b1, 2'h1, {2'h0, s});
        take(n);
        for (int k = 0; k < n; k++) begin
            cmp(cols[k], il ? s ^ k[9:0] : (s & ~w) | ((s + k[9:0]) & w));
        end
        repeat (10) @(posedge mclk);
        cmp(cols.size(), n);
        $display("burst length %0d done", n);
    endtask : burst
    // ==========================================================
    // Tests
    initial begin
        sys_rst = 1'b1;
        beat_ready = 1'b1;
        rd_valid = 1'b0;
        rd_data = '0;
        repeat (4) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        cmp(mode_value, 12'h020);
        repeat (2) h.issue(4'h1, 1'b1, 2'h0, 12'h000);
        h.issue(4'h3, 1'b1, 2'h2, 12'h005);
        wt();
        cmp({act_pulse, act_bank, act_row, open_banks}, {1'b1, 2'h2, 12'h005, 4'h4});
        h.issue(4'hb, 1'b1, 2'h1, 12'h007);
        wt();
        cmp({act_pulse, act_row, open_banks}, {1'b0, 12'h005, 4'h4});
        h.issue(4'h2, 1'b1, 2'h2, 12'h000);
        wt();
        cmp({pre_pulse, pre_banks, open_banks}, {1'b1, 4'h4, 4'h0});
        h.issue(4'h2, 1'b1, 2'h1, 12'h400);
        wt();
        cmp({pre_pulse, pre_banks}, {1'b1, 4'hf});
        $display("row commands done");
        h.issue(4'h1, 1'b1, 2'h3, 12'hfff);
        wt();
        cmp({rfsh_pulse, self_refresh, rfsh_row}, {2'h2, 12'h002});
        h.issue(4'h1, 1'b0, 2'h0, 12'h000);
        wt();
        cmp({rfsh_pulse, self_refresh}, 2'h1);
        repeat (3) @(posedge mclk);
        $display("refresh done");
        cols.delete();
        h.issue(4'h4, 1'b1, 2'h1, 12'h403, 8'h0f, 64'h0123456789abcdef);
        take(1);
        cmp(got_b, {1'b1, 2'h1, 10'h003, 2'h3, 8'h0f, 64'h0123456789abcdef});
        $display("write done");
        h.issue(4'h5, 1'b1, 2'h0, 12'h000, 8'h01);
        repeat (3) @(posedge mclk);
        #1;
        rd_valid = 1'b1;
        rd_data = 64'hfedcba9876543210;
        @(posedge mclk);
        #1;
        rd_valid = 1'b0;
        cmp({dq_oe_n, dq_out}, {8'h01, 64'hfedcba9876543210});
        @(posedge mclk);
        #1;
        cmp(dq_oe_n, 8'hff);
        $display("read data done");
        burst(3'h1, 1'b0, 10'h001);
        burst(3'h2, 1'b1, 10'h001);
        burst(3'h3, 1'b1, 10'h005);
        burst(3'h3, 1'b0, 10'h006);
        burst(3'h0, 1'b1, 10'h003);
        // Five single writes into a stalled FIFO: one beat is lost
        cols.delete();
        beat_ready = 1'b0;
        repeat (5) h.issue(4'h4, 1'b1, 2'h0, 12'h000);
        take(sdcbd_pkg::FIFO_DEPTH);
        repeat (10) @(posedge mclk);
        cmp({ovr_n, cols.size()}, {32'd1, sdcbd_pkg::FIFO_DEPTH});
        $display("overrun done");
        // Full page with the interleave bit set runs sequentially and wraps the row
        h.issue(4'h0, 1'b1, 2'h0, 12'h02f);
        wt();
        cols.delete();
        h.issue(4'h5, 1'b1, 2'h0, 12'h3fe);
        take(3);
        h.issue(4'h6, 1'b1, 2'h0, 12'h000);
        cmp({cols[0], cols[1], cols[2]}, {10'h3fe, 10'h3ff, 10'h000});
        $display("page burst done");
        test_done();
    end
endmodule : tb_sdcbd_top
